// ### shared/crsz_cfg.svh
`ifndef CRSZ_CFG_SVH
`define CRSZ_CFG_SVH

// register byte offsets
`define CRSZ_OFS_GLOBAL_CTRL   8'h60
`define CRSZ_OFS_SEQ_STATE     8'h64
`define CRSZ_OFS_FORMAT        8'h68
`define CRSZ_OFS_RSVD_FIRST    8'h70
`define CRSZ_OFS_RSVD_LAST     8'h7c
`define CRSZ_OFS_ENABLE_RESET  8'hc0
`define CRSZ_OFS_START_X       8'hc8
`define CRSZ_OFS_START_Y       8'hcc

// widths
`define CRSZ_ADDR_W            8
`define CRSZ_DATA_W            16
`define CRSZ_POS_W             11
`define CRSZ_STATE_W           4

// field positions
`define CRSZ_BIT_CONTINUE      8
`define CRSZ_BIT_FORMAT        0
`define CRSZ_BIT_SOFT_RESET    7
`define CRSZ_BIT_ENABLE        0

// reset values
`define CRSZ_RST_DATA          16'h0000
`define CRSZ_RST_POS           11'h000
`define CRSZ_RST_FORMAT        1'b0
`define CRSZ_RST_ENABLE        1'b0

// format select codes
`define CRSZ_FMT_YUV           1'b0
`define CRSZ_FMT_COMPRESSED    1'b1

// state values shown to software
`define CRSZ_SV_IDLE           4'h0
`define CRSZ_SV_ARMED          4'h1
`define CRSZ_SV_ACTIVE         4'h2

`endif

// ### shared/crsz_pkg.sv
`default_nettype none

package crsz_pkg;

  typedef enum logic [2:0] {
    CRSZ_ST_IDLE   = 3'b001,
    CRSZ_ST_ARMED  = 3'b010,
    CRSZ_ST_ACTIVE = 3'b100
  } crsz_state_type;

endpackage

`default_nettype wire

// ### logic/crsz_pos_counter.sv
`timescale 1ns/1ns
`default_nettype none

module crsz_pos_counter #(
  parameter int W = 11
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // control
  input  wire logic         cnt_en,
  input  wire logic         clr,
  input  wire logic         step,
  // position
  output logic [W-1:0]      pos
);

  logic [W-1:0] pos_ff;

  // saturates so an oversize frame never wraps back into the window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pos_ff <= '0;
    end else if (cnt_en) begin
      if (clr) begin
        pos_ff <= '0;
      end else if (step && (pos_ff != {W{1'b1}})) begin
        pos_ff <= pos_ff + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign pos = pos_ff;

endmodule

`default_nettype wire

// ### logic/crsz_top.sv
// Function
// - Writing one to bit 8 of the global control register forwards the following frame too.
// - The capture state register shows the sequencer state as a four-bit value in bits 3:0.
// - Bit 0 of the format register selects pixel data (0) or compressed image data (1).
// - In compressed format every resizer setting except the control register is ignored.
// - Writing one to bit 7 of the control register soft-resets the resizer; zero does nothing.
// - Enable bit 0 low stops the resize logic clock; high enables the resizer.
// - All registers stay readable and writable while the resizer is disabled.
// - Reading the enable bit returns the present enable state.
// - Capture of each frame starts at the 11-bit start X pixel position.
`timescale 1ns/1ns
`default_nettype none
`include "crsz_cfg.svh"

module crsz_top
  import crsz_pkg::*;
(
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // register port
  input  wire logic [`CRSZ_ADDR_W-1:0]   reg_addr,
  input  wire logic [`CRSZ_DATA_W-1:0]   reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [`CRSZ_DATA_W-1:0]   reg_rdata,
  // capture request
  input  wire logic                      capture_start,
  // camera capture side
  input  wire logic                      cam_frame_start,
  input  wire logic                      cam_frame_end,
  input  wire logic                      cam_line_start,
  input  wire logic                      cam_line_end,
  input  wire logic                      cam_pixel_valid,
  input  wire logic [`CRSZ_DATA_W-1:0]   cam_pixel_data,
  // image codec side
  output logic                           codec_frame_start,
  output logic                           codec_frame_end,
  output logic                           codec_valid,
  output logic      [`CRSZ_DATA_W-1:0]   codec_data,
  // resize clock enable
  output logic                           resize_clk_en
);

  crsz_state_type              state_ff;
  crsz_state_type              nxt_state;
  logic                        enable_ff;
  logic                        format_ff;
  logic [`CRSZ_POS_W-1:0]      start_x_ff;
  logic [`CRSZ_POS_W-1:0]      start_y_ff;
  logic                        cont_pending_ff;
  logic [`CRSZ_DATA_W-1:0]     rdata_ff;
  logic [`CRSZ_DATA_W-1:0]     nxt_rdata;
  logic                        frame_start_ff;
  logic                        frame_end_ff;
  logic                        valid_ff;
  logic [`CRSZ_DATA_W-1:0]     data_ff;

  logic                        wr_global;
  logic                        wr_format;
  logic                        wr_ctrl;
  logic                        wr_start_x;
  logic                        wr_start_y;
  logic                        soft_reset;
  logic                        cont_set;
  logic                        cont_take;
  logic                        seq_rst;
  logic                        compressed;
  logic                        in_window;
  logic                        frame_done;
  logic [`CRSZ_POS_W-1:0]      pos_x;
  logic [`CRSZ_POS_W-1:0]      pos_y;
  logic [`CRSZ_STATE_W-1:0]    state_value;

  // write decode
  always_comb begin
    wr_global  = 1'b0;
    wr_format  = 1'b0;
    wr_ctrl    = 1'b0;
    wr_start_x = 1'b0;
    wr_start_y = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `CRSZ_OFS_GLOBAL_CTRL) begin
        wr_global = 1'b1;
      end else if (reg_addr == `CRSZ_OFS_FORMAT) begin
        wr_format = 1'b1;
      end else if (reg_addr == `CRSZ_OFS_ENABLE_RESET) begin
        wr_ctrl = 1'b1;
      end else if (reg_addr == `CRSZ_OFS_START_X) begin
        wr_start_x = 1'b1;
      end else if (reg_addr == `CRSZ_OFS_START_Y) begin
        wr_start_y = 1'b1;
      end
    end
  end

  assign soft_reset = wr_ctrl && reg_wdata[`CRSZ_BIT_SOFT_RESET];
  assign seq_rst    = rst || soft_reset;
  assign cont_set   = wr_global && reg_wdata[`CRSZ_BIT_CONTINUE];
  assign compressed = (format_ff == `CRSZ_FMT_COMPRESSED);

  // enable lives outside the soft reset so a reset write can also set it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_ff <= `CRSZ_RST_ENABLE;
    end else if (wr_ctrl) begin
      enable_ff <= reg_wdata[`CRSZ_BIT_ENABLE];
    end
  end

  assign resize_clk_en = enable_ff;

  // configuration registers take writes whatever the enable state
  always_ff @(posedge core_clk) begin
    if (seq_rst) begin
      format_ff <= `CRSZ_RST_FORMAT;
    end else if (wr_format) begin
      format_ff <= reg_wdata[`CRSZ_BIT_FORMAT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (seq_rst) begin
      start_x_ff <= `CRSZ_RST_POS;
    end else if (wr_start_x) begin
      start_x_ff <= reg_wdata[`CRSZ_POS_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (seq_rst) begin
      start_y_ff <= `CRSZ_RST_POS;
    end else if (wr_start_y) begin
      start_y_ff <= reg_wdata[`CRSZ_POS_W-1:0];
    end
  end

  // continue request: a new write wins over the frame-end consumption
  always_ff @(posedge core_clk) begin
    if (seq_rst) begin
      cont_pending_ff <= 1'b0;
    end else if (cont_set) begin
      cont_pending_ff <= 1'b1;
    end else if (cont_take) begin
      cont_pending_ff <= 1'b0;
    end
  end

  // window position counters, frozen with the resize clock
  crsz_pos_counter #(
    .W (`CRSZ_POS_W)
  ) u_pos_x (
    .core_clk (core_clk),
    .rst      (seq_rst),
    .cnt_en   (enable_ff),
    .clr      (cam_line_start),
    .step     (cam_pixel_valid),
    .pos      (pos_x)
  );

  crsz_pos_counter #(
    .W (`CRSZ_POS_W)
  ) u_pos_y (
    .core_clk (core_clk),
    .rst      (seq_rst),
    .cnt_en   (enable_ff),
    .clr      (cam_frame_start),
    .step     (cam_line_end),
    .pos      (pos_y)
  );

  // compressed data bypasses the window entirely
  always_comb begin
    if (compressed) begin
      in_window = 1'b1;
    end else begin
      in_window = (pos_x >= start_x_ff) && (pos_y >= start_y_ff);
    end
  end

  assign frame_done = (state_ff == CRSZ_ST_ACTIVE) && cam_frame_end;
  // continuous mode belongs to the ignored settings in compressed format
  assign cont_take  = enable_ff && frame_done && cont_pending_ff && !compressed;

  // capture sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CRSZ_ST_IDLE: begin
        if (capture_start) begin
          nxt_state = CRSZ_ST_ARMED;
        end
      end
      CRSZ_ST_ARMED: begin
        if (cam_frame_start) begin
          nxt_state = CRSZ_ST_ACTIVE;
        end
      end
      CRSZ_ST_ACTIVE: begin
        if (cam_frame_end) begin
          if (cont_pending_ff && !compressed) begin
            nxt_state = CRSZ_ST_ARMED;
          end else begin
            nxt_state = CRSZ_ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = CRSZ_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (seq_rst) begin
      state_ff <= CRSZ_ST_IDLE;
    end else if (enable_ff) begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    case (state_ff)
      CRSZ_ST_ARMED: begin
        state_value = `CRSZ_SV_ARMED;
      end
      CRSZ_ST_ACTIVE: begin
        state_value = `CRSZ_SV_ACTIVE;
      end
      default: begin
        state_value = `CRSZ_SV_IDLE;
      end
    endcase
  end

  // codec-side outputs, all registered
  always_ff @(posedge core_clk) begin
    if (seq_rst) begin
      frame_start_ff <= 1'b0;
      frame_end_ff   <= 1'b0;
    end else begin
      frame_start_ff <= enable_ff && (state_ff == CRSZ_ST_ARMED) && cam_frame_start;
      frame_end_ff   <= enable_ff && frame_done;
    end
  end

  always_ff @(posedge core_clk) begin
    if (seq_rst) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= enable_ff && (state_ff == CRSZ_ST_ACTIVE) && cam_pixel_valid
                  && in_window;
    end
  end

  // data register only loads on a forwarded pixel to save toggling
  always_ff @(posedge core_clk) begin
    if (seq_rst) begin
      data_ff <= `CRSZ_RST_DATA;
    end else if (enable_ff && (state_ff == CRSZ_ST_ACTIVE) && cam_pixel_valid
                 && in_window) begin
      data_ff <= cam_pixel_data;
    end
  end

  assign codec_frame_start = frame_start_ff;
  assign codec_frame_end   = frame_end_ff;
  assign codec_valid       = valid_ff;
  assign codec_data        = data_ff;

  // read decode; write-only bits and reserved space read as zero
  always_comb begin
    nxt_rdata = `CRSZ_RST_DATA;
    if (reg_addr == `CRSZ_OFS_SEQ_STATE) begin
      nxt_rdata[`CRSZ_STATE_W-1:0] = state_value;
    end else if (reg_addr == `CRSZ_OFS_FORMAT) begin
      nxt_rdata[`CRSZ_BIT_FORMAT] = format_ff;
    end else if (reg_addr == `CRSZ_OFS_ENABLE_RESET) begin
      nxt_rdata[`CRSZ_BIT_ENABLE] = enable_ff;
    end else if (reg_addr == `CRSZ_OFS_START_X) begin
      nxt_rdata[`CRSZ_POS_W-1:0] = start_x_ff;
    end else if (reg_addr == `CRSZ_OFS_START_Y) begin
      nxt_rdata[`CRSZ_POS_W-1:0] = start_y_ff;
    end
  end

  // read port is not gated by the enable bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_ff <= `CRSZ_RST_DATA;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= `CRSZ_RST_DATA;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

`default_nettype wire

// ### dv/crsz_cam_model.sv
`timescale 1ns/1ns
`default_nettype none

module crsz_cam_model (
  // clock
  input  wire logic   core_clk,
  // camera strobes
  output logic        cam_frame_start,
  output logic        cam_line_start,
  output logic        cam_pixel_valid,
  output logic        cam_line_end,
  output logic        cam_frame_end,
  // pixel word
  output logic [15:0] cam_pixel_data
);
  initial begin
    {cam_frame_start, cam_line_start, cam_pixel_valid, cam_line_end, cam_frame_end} = '0;
    cam_pixel_data = 16'h5a5a;
  end

  // between pixels the word flips so a stale value never passes for a fresh one
  task automatic put(input logic [4:0] v, input logic [15:0] d);
    {cam_frame_start, cam_line_start, cam_pixel_valid, cam_line_end, cam_frame_end} <= v;
    cam_pixel_data <= v[2] ? d : ~cam_pixel_data;
    @(posedge core_clk);
  endtask

  task automatic frame(input int nl, input int np);
    put(5'b10000, 16'h0000);
    for (int l = 0; l < nl; l++) begin
      put(5'b01000, 16'h0000);
      for (int p = 0; p < np; p++) put(5'b00100, 16'ha000 + 16'(l * 256 + p));
      put(5'b00010, 16'h0000);
    end
    put(5'b00001, 16'h0000);
    put(5'b00000, 16'h0000);
  endtask
endmodule

`default_nettype wire

// ### dv/crsz_top_sva.sv
`timescale 1ns/1ns
`default_nettype none

module crsz_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // capture link
  input wire logic        cam_frame_start,
  input wire logic        cam_frame_end,
  input wire logic        codec_frame_start,
  input wire logic        codec_frame_end,
  input wire logic        codec_valid,
  input wire logic        resize_clk_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_RDATA_SLOT: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  AST_CONT_WO: assert property (reg_rd && reg_addr == 8'h60 |=> reg_rdata == 16'h0000)
    else $error("write-only control read back");
  AST_RSVD_ZERO: assert property (reg_rd && reg_addr[7:4] == 4'h7 |=> reg_rdata == 16'h0000)
    else $error("reserved range not zero");
  AST_STATE_FIELD: assert property (reg_rd && reg_addr == 8'h64 |=> reg_rdata[15:4] == 12'h000)
    else $error("state upper bits set");
  AST_SRST_WO: assert property (reg_rd && reg_addr == 8'hc0 |=> reg_rdata[15:1] == 15'h0000)
    else $error("reset bit read back");
  AST_EN_FOLLOW: assert property (reg_wr && reg_addr == 8'hc0 |=> resize_clk_en == $past(reg_wdata[0]))
    else $error("clock enable not following write");
  AST_EN_READ: assert property (reg_rd && reg_addr == 8'hc0 |=> reg_rdata[0] == $past(resize_clk_en))
    else $error("enable readback wrong");
  AST_POS_FIELD: assert property (reg_rd && reg_addr[7:3] == 5'b11001 |=> reg_rdata[15:11] == 5'h00)
    else $error("position upper bits set");
  AST_GATED_QUIET: assert property (!$past(resize_clk_en) |-> !codec_valid)
    else $error("codec word while disabled");
  AST_FSTART_CAUSE: assert property (codec_frame_start |-> $past(cam_frame_start))
    else $error("codec frame start without cause");
  AST_FEND_CAUSE: assert property (codec_frame_end |-> $past(cam_frame_end))
    else $error("codec frame end without cause");

  cover property (codec_valid);
  cover property (codec_frame_start);
  cover property (reg_wr && reg_addr == 8'hc0 && reg_wdata[7]);
endmodule

bind crsz_top crsz_checker chk_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .cam_frame_start, .cam_frame_end, .codec_frame_start, .codec_frame_end,
  .codec_valid, .resize_clk_en);

`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic        core_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        capture_start;
  logic        fs, fe, ls, le, pv;
  logic [15:0] pd;
  logic        codec_valid;
  logic [15:0] codec_data;
  logic        cfs;
  logic        cfe;
  int          n_fs;
  int          n_fe;
  // every register offset, read back once after reset
  localparam logic [63:0] OFS_LIST = 64'h60_64_68_70_7c_c0_c8_cc;
  logic        rd_q;
  logic [31:0] seed;
  logic [15:0] rq[$];
  logic [15:0] cq[$];
  int          n_fail;
  int          compares;
  int          sx, sy;

  crsz_top dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .capture_start, .cam_frame_start(fs), .cam_frame_end(fe), .cam_line_start(ls),
    .cam_line_end(le), .cam_pixel_valid(pv), .cam_pixel_data(pd), .codec_frame_start(cfs),
    .codec_frame_end(cfe), .codec_valid, .codec_data, .resize_clk_en());
  crsz_cam_model cam_u (.core_clk, .cam_frame_start(fs), .cam_line_start(ls),
    .cam_pixel_valid(pv), .cam_line_end(le), .cam_frame_end(fe), .cam_pixel_data(pd));

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[30:0]);
  endfunction

  task automatic chk(input logic [15:0] e, input logic [15:0] g, input string n);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  // d is write data for a write, the expected answer for a read
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) rq.push_back(d);
    @(posedge core_clk);
  endtask

  task automatic nop(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask

  task automatic cap();
    capture_start <= 1'b1;
    nop(1);
    capture_start <= 1'b0;
    nop(1);
  endtask

  task automatic expect_frame(input int nl, input int np, input logic cmp);
    for (int l = 0; l < nl; l++)
      for (int p = 0; p < np; p++)
        if (cmp || (l >= sy && p >= sx)) cq.push_back(16'ha000 + 16'(l * 256 + p));
  endtask

  task automatic stop_test();
    chk(16'h0000, 16'(rq.size() + cq.size()), "pending");
    chk(16'h0003, 16'(n_fs), "codec_frame_start");
    chk(16'h0003, 16'(n_fe), "codec_frame_end");
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (rd_q) chk(rq.size() ? rq.pop_front() : 16'hxxxx, reg_rdata, "reg_rdata");
    if (codec_valid === 1'b1) chk(cq.size() ? cq.pop_front() : 16'hxxxx, codec_data, "codec");
    if (cfs === 1'b1) n_fs++;
    if (cfe === 1'b1) n_fe++;
    rd_q <= reg_rd;
  end

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    stop_test();
  end

  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, capture_start, rd_q} = '0;
    {n_fail, compares, n_fs, n_fe} = '0;
    seed = 32'd64941;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) bus(1'b0, 1'b1, OFS_LIST[8 * (7 - i) +: 8], 16'h0000);
    sx = rnd() % 2048;
    bus(1'b1, 1'b0, 8'hc8, 16'(sx));
    bus(1'b0, 1'b1, 8'hc8, 16'(sx));
    sx = rnd() % 4;
    sy = rnd() % 3;
    bus(1'b1, 1'b0, 8'hc8, 16'(sx));
    bus(1'b1, 1'b0, 8'hcc, 16'(sy));
    bus(1'b1, 1'b0, 8'hc0, 16'h0001);
    bus(1'b0, 1'b1, 8'hc0, 16'h0001);
    bus(1'b1, 1'b0, 8'h60, 16'h0100);
    cap();
    bus(1'b0, 1'b1, 8'h64, 16'h0001);
    nop(1);
    expect_frame(4, 4, 1'b0);
    cam_u.frame(4, 4);
    bus(1'b0, 1'b1, 8'h64, 16'h0001);
    nop(1);
    expect_frame(4, 4, 1'b0);
    cam_u.frame(4, 4);
    bus(1'b0, 1'b1, 8'h64, 16'h0000);
    bus(1'b1, 1'b0, 8'h68, 16'h0001);
    bus(1'b0, 1'b1, 8'h68, 16'h0001);
    cap();
    expect_frame(2, 3, 1'b1);
    cam_u.frame(2, 3);
    bus(1'b1, 1'b0, 8'hcc, 16'h07ff);
    bus(1'b1, 1'b0, 8'hc0, 16'h0001);
    bus(1'b0, 1'b1, 8'hcc, 16'h07ff);
    bus(1'b1, 1'b0, 8'hc0, 16'h0081);
    bus(1'b0, 1'b1, 8'hcc, 16'h0000);
    bus(1'b0, 1'b1, 8'h68, 16'h0000);
    bus(1'b0, 1'b1, 8'hc0, 16'h0001);
    bus(1'b1, 1'b0, 8'hc0, 16'h0000);
    cap();
    cam_u.frame(2, 2);
    bus(1'b0, 1'b1, 8'h64, 16'h0000);
    nop(3);
    stop_test();
  end
endmodule

`default_nettype wire
